// *** rtl/flash_led_driver_config_regs_map.vh ***
`ifndef FLASH_LED_DRIVER_CONFIG_REGS_MAP_VH
`define FLASH_LED_DRIVER_CONFIG_REGS_MAP_VH

// ----------------------------------------------------------------------------
// serial bus address bytes (address plus direction bit)
// ----------------------------------------------------------------------------
`define I2C_WR_ADDR          8'h60
`define I2C_RD_ADDR          8'h61

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define REG_SILICON_REV      8'h01
`define REG_THR_DURATION     8'h02
`define REG_LED_CURRENTS     8'h03
`define REG_OP_CONFIG        8'h04
`define REG_FAULT_FLAGS      8'h05
`define REG_TRIG_SETTINGS    8'h06

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define THR_RST              2'h0
`define DURATION_RST         4'hf
`define FLASH_CUR_RST        4'h6
`define ASSIST_CUR_RST       3'h1
`define OP_CONFIG_RST        8'hb4
`define LED_TWO_RST          1'b1
`define TRIG_POL_RST         1'b1
`define THROTTLE_EN_RST      1'b1
`define PIN_IDLE_RST         9'h003

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define OPC_ILIM_HI          7
`define OPC_ILIM_LO          6
`define OPC_TRIG_LEVEL       5
`define OPC_CONT_ALLOW       4
`define OPC_DETECT_ON        3
`define OPC_TRIG_EN          2
`define OPC_MODE_HI          1
`define OPC_MODE_LO          0
`define FLT_OVERVOLT         7
`define FLT_SHORT            6
`define FLT_OVERTEMP         5
`define FLT_TIMEOUT          4
`define FLT_LED_TWO          3
`define FLT_CUR_LIMIT        1
`define TRG_POLARITY         2
`define TRG_THROTTLE_EN      1

// ----------------------------------------------------------------------------
// operating modes
// ----------------------------------------------------------------------------
`define MODE_STANDBY         2'h0
`define MODE_RESERVED        2'h1
`define MODE_FLASH           2'h3

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define FLASH_TIMEOUT_MS     850
`define CLK_FREQ_KHZ         125000

`endif

// *** rtl/flash_led_driver_config_regs.v ***
`timescale 1ns/10ps
`include "flash_led_driver_config_regs_map.vh"

module flash_led_driver_config_regs #(
    parameter [31:0] TIMEOUT_CYCLES = `FLASH_TIMEOUT_MS * `CLK_FREQ_KHZ,
    parameter        TO_W           = 27,
    parameter [7:0]  REVISION_ID    = 8'h5a  // arbitrary value
) (
    // clock, reset, enable
    input  wire       clock,
    input  wire       rst_b,
    input  wire       ce,
    // serial bus pins
    input  wire       scl,
    input  wire       sda_in,
    output reg        sda_out_q,
    output reg        sda_oe_q,
    // control pins
    input  wire       strobe_pin,
    input  wire       torch_pin,
    input  wire       tx_mask_pin,
    // fault detectors (levels from analog side)
    input  wire       fault_overvolt,
    input  wire       fault_short,
    input  wire       fault_overtemp,
    input  wire       fault_cur_limit,
    // configuration toward analog side
    output reg [1:0]  thr_sel_q,
    output reg [3:0]  flash_duration_q,
    output reg [3:0]  flash_current_q,
    output reg [2:0]  assist_current_q,
    output reg [7:0]  op_config_q,
    output reg        led_two_q,
    output reg        trig_polarity_q,
    output reg        throttle_en_q,
    // derived control
    output reg [1:0]  led_mode_q,
    output reg        led_enable_q,
    output reg        flash_trigger_q,
    output reg        torch_on_q,
    output reg        throttle_q,
    output reg [4:0]  fault_q
);

    // ------------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------------
    localparam NSYNC = 9;
    localparam [NSYNC-1:0] SYNC_RST = `PIN_IDLE_RST;  // bus lines idle high, the rest low
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_ADDR  = 3'd1;
    localparam [2:0] ST_ACK   = 3'd2;
    localparam [2:0] ST_WRITE = 3'd3;
    localparam [2:0] ST_READ  = 3'd4;
    localparam [2:0] ST_MACK  = 3'd5;
    localparam [31:0] TO_LAST32 = TIMEOUT_CYCLES - 32'd1;
    localparam [TO_W-1:0] TO_LAST = TO_LAST32[TO_W-1:0];

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    wire [NSYNC-1:0] raw_in;
    reg  [NSYNC-1:0] meta_q;   // first stage, read only by sync_q
    reg  [NSYNC-1:0] sync_q;   // safe copies
    assign raw_in = {fault_cur_limit, fault_overtemp, fault_short, fault_overvolt,
                     tx_mask_pin, torch_pin, strobe_pin, sda_in, scl};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            // two flops per pin; idle-level reset so no false fault or edge
            always @(posedge clock) begin
                if (!rst_b) begin
                    meta_q[gi] <= SYNC_RST[gi];
                    sync_q[gi] <= SYNC_RST[gi];
                end else if (ce) begin
                    meta_q[gi] <= raw_in[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate
    wire scl_s    = sync_q[0];
    wire sda_s    = sync_q[1];
    wire strobe_s = sync_q[2];
    wire torch_s  = sync_q[3];
    wire txm_s    = sync_q[4];
    wire [3:0] flt_s = sync_q[8:5];  // cur_limit, overtemp, short, overvolt

    // ------------------------------------------------------------------------
    // bus edge and condition detection
    // ------------------------------------------------------------------------
    reg  scl_d_q;                     // previous scl sample
    reg  sda_d_q;                     // previous sda sample
    reg  strobe_d_q;                  // previous trigger sample
    wire scl_rise = scl_s & ~scl_d_q;
    wire scl_fall = ~scl_s & scl_d_q;
    wire bus_start = scl_s & scl_d_q & sda_d_q & ~sda_s;
    wire bus_stop  = scl_s & scl_d_q & ~sda_d_q & sda_s;

    // ------------------------------------------------------------------------
    // slave state
    // ------------------------------------------------------------------------
    reg [2:0] state_q;                // protocol state
    reg [2:0] bit_cnt_q;              // bit in current byte
    reg       got8_q;                 // eighth bit taken
    reg [7:0] shift_q;                // rx / tx shifter
    reg       rw_q;                   // 1 = read transfer
    reg       sub_done_q;             // subaddress already taken
    reg [7:0] ptr_q;                  // register pointer
    reg [7:0] rd_data;                // read mux
    reg [TO_W-1:0] to_cnt_q;          // level-trigger active duration counter
    wire [7:0] rx_byte = {shift_q[6:0], sda_s};

    // completed read of the fault register clears its flags
    wire fault_read_done = (state_q == ST_MACK) & scl_rise & ~bus_start & ~bus_stop &
                           (ptr_q == `REG_FAULT_FLAGS);

    // ------------------------------------------------------------------------
    // read data mux; unmapped and reserved bits read zero
    // ------------------------------------------------------------------------
    always @* begin
        case (ptr_q)
            `REG_SILICON_REV:   rd_data = REVISION_ID;
            `REG_THR_DURATION:  rd_data = {2'b00, thr_sel_q, flash_duration_q};
            `REG_LED_CURRENTS:  rd_data = {flash_current_q, 1'b0, assist_current_q};
            `REG_OP_CONFIG:     rd_data = op_config_q;
            `REG_FAULT_FLAGS:   rd_data = {fault_q[4], fault_q[3], fault_q[2], fault_q[1],
                                           led_two_q, 1'b0, fault_q[0], 1'b0};
            `REG_TRIG_SETTINGS: rd_data = {5'b00000, trig_polarity_q, throttle_en_q, 1'b0};
            default:            rd_data = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------------
    // bus protocol engine and register writes
    // ------------------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_b) begin
            state_q          <= ST_IDLE;
            bit_cnt_q        <= 3'd0;
            got8_q           <= 1'b0;
            shift_q          <= 8'h00;
            rw_q             <= 1'b0;
            sub_done_q       <= 1'b0;
            ptr_q            <= 8'h00;
            sda_out_q        <= 1'b0;
            sda_oe_q         <= 1'b0;
            scl_d_q          <= 1'b1;
            sda_d_q          <= 1'b1;
            thr_sel_q        <= `THR_RST;
            flash_duration_q <= `DURATION_RST;
            flash_current_q  <= `FLASH_CUR_RST;
            assist_current_q <= `ASSIST_CUR_RST;
            op_config_q      <= `OP_CONFIG_RST;
            led_two_q        <= `LED_TWO_RST;
            trig_polarity_q  <= `TRIG_POL_RST;
            throttle_en_q    <= `THROTTLE_EN_RST;
        end else if (ce) begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
            if (bus_start) begin
                // repeated start keeps the pointer
                state_q    <= ST_ADDR;
                bit_cnt_q  <= 3'd0;
                got8_q     <= 1'b0;
                sub_done_q <= 1'b0;
                sda_oe_q   <= 1'b0;
            end else if (bus_stop) begin
                state_q  <= ST_IDLE;
                sda_oe_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift_q   <= rx_byte;
                            bit_cnt_q <= bit_cnt_q + 3'd1;
                            got8_q    <= (bit_cnt_q == 3'd7);
                        end else if (scl_fall && got8_q) begin
                            got8_q <= 1'b0;
                            // only our two address bytes get an ack
                            if (shift_q == `I2C_WR_ADDR || shift_q == `I2C_RD_ADDR) begin
                                rw_q     <= shift_q[0];
                                sda_oe_q <= 1'b1;
                                state_q  <= ST_ACK;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_q <= 3'd0;
                            if (rw_q) begin
                                // first data bit goes out as the ack slot ends
                                sda_oe_q <= ~rd_data[7];
                                shift_q  <= {rd_data[6:0], 1'b0};
                                state_q  <= ST_READ;
                            end else begin
                                sda_oe_q <= 1'b0;
                                state_q  <= ST_WRITE;
                            end
                        end
                    end
                    ST_WRITE: begin
                        if (scl_rise) begin
                            shift_q   <= rx_byte;
                            bit_cnt_q <= bit_cnt_q + 3'd1;
                            if (bit_cnt_q == 3'd7) begin
                                got8_q <= 1'b1;
                                if (!sub_done_q) begin
                                    ptr_q      <= rx_byte;
                                    sub_done_q <= 1'b1;
                                end else begin
                                    ptr_q <= ptr_q + 8'd1;
                                    case (ptr_q)
                                        `REG_THR_DURATION: begin
                                            thr_sel_q        <= rx_byte[5:4];
                                            flash_duration_q <= rx_byte[3:0];
                                        end
                                        `REG_LED_CURRENTS: begin
                                            flash_current_q  <= rx_byte[7:4];
                                            assist_current_q <= rx_byte[2:0];
                                        end
                                        `REG_OP_CONFIG:
                                            op_config_q <= rx_byte;
                                        `REG_FAULT_FLAGS:
                                            led_two_q <= rx_byte[`FLT_LED_TWO];
                                        `REG_TRIG_SETTINGS: begin
                                            trig_polarity_q <= rx_byte[`TRG_POLARITY];
                                            throttle_en_q   <= rx_byte[`TRG_THROTTLE_EN];
                                        end
                                        default: ;
                                    endcase
                                end
                            end
                        end else if (scl_fall && got8_q) begin
                            got8_q   <= 1'b0;
                            sda_oe_q <= 1'b1;
                            state_q  <= ST_ACK;
                        end
                    end
                    ST_READ: begin
                        if (scl_rise) begin
                            bit_cnt_q <= bit_cnt_q + 3'd1;
                            got8_q    <= (bit_cnt_q == 3'd7);
                        end else if (scl_fall) begin
                            if (got8_q) begin
                                // release the line for the master's ack
                                got8_q   <= 1'b0;
                                sda_oe_q <= 1'b0;
                                state_q  <= ST_MACK;
                            end else begin
                                sda_oe_q <= ~shift_q[7];
                                shift_q  <= {shift_q[6:0], 1'b0};
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            ptr_q   <= ptr_q + 8'd1;
                            // nack ends the read; ack loads the next register
                            state_q <= sda_s ? ST_IDLE : ST_ACK;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // fault flags, trigger timing and derived controls
    // ------------------------------------------------------------------------
    // a new fault in the clearing cycle survives: set beats clear
    wire       to_hit   = (to_cnt_q == TO_LAST);
    wire [4:0] flt_set  = {flt_s[0], flt_s[1], flt_s[2], to_hit, flt_s[3]};
    wire [4:0] fault_d  = (fault_q & {5{~fault_read_done}}) | flt_set;
    wire       trig_lvl = (strobe_s == trig_polarity_q);
    wire       trig_edge = (strobe_s != strobe_d_q) & trig_lvl;
    wire       level_run = op_config_q[`OPC_TRIG_EN] & op_config_q[`OPC_TRIG_LEVEL] & trig_lvl;
    wire [1:0] mode_cfg = op_config_q[`OPC_MODE_HI:`OPC_MODE_LO];

    always @(posedge clock) begin
        if (!rst_b) begin
            fault_q         <= 5'h00;
            to_cnt_q        <= {TO_W{1'b0}};
            strobe_d_q      <= 1'b0;
            led_mode_q      <= `MODE_STANDBY;
            led_enable_q    <= 1'b0;
            flash_trigger_q <= 1'b0;
            torch_on_q      <= 1'b0;
            throttle_q      <= 1'b0;
        end else if (ce) begin
            fault_q    <= fault_d;
            strobe_d_q <= strobe_s;
            // count a level-held trigger; holds at the limit until it drops
            if (!level_run)
                to_cnt_q <= {TO_W{1'b0}};
            else if (!to_hit)
                to_cnt_q <= to_cnt_q + {{(TO_W-1){1'b0}}, 1'b1};
            // reserved code gives no current
            led_mode_q   <= (mode_cfg == `MODE_RESERVED) ? `MODE_STANDBY : mode_cfg;
            // any standing flag keeps the driver off until it is read
            led_enable_q <= ~|fault_d;
            if (!op_config_q[`OPC_TRIG_EN])
                flash_trigger_q <= 1'b0;
            else if (op_config_q[`OPC_TRIG_LEVEL])
                flash_trigger_q <= trig_lvl;
            else
                flash_trigger_q <= trig_edge;
            torch_on_q <= op_config_q[`OPC_CONT_ALLOW] & torch_s;
            throttle_q <= throttle_en_q & txm_s;
        end
    end

endmodule

// *** tb/flash_led_driver_config_regs_assertions.sv ***
`timescale 1ns/10ps
module flash_led_driver_config_regs_assertions (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst_b,
    // pins seen by the block
    input wire logic       strobe_pin,
    input wire logic       fault_overvolt,
    // configuration fields
    input wire logic [1:0] thr_sel_q,
    input wire logic [1:0] led_mode_q,
    input wire logic [3:0] flash_duration_q,
    input wire logic [3:0] flash_current_q,
    input wire logic [2:0] assist_current_q,
    input wire logic [7:0] op_config_q,
    input wire logic       led_two_q,
    input wire logic       trig_polarity_q,
    input wire logic       throttle_en_q,
    // derived control and flags
    input wire logic [4:0] fault_q,
    input wire logic       led_enable_q,
    input wire logic       flash_trigger_q,
    input wire logic       torch_on_q,
    input wire logic       throttle_q
);
    // ------------------------------------------------------------------
    // properties, all in the one clock domain
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // strobe active in level mode long enough to cross the synchroniser
    sequence s_level_active;
        (op_config_q[5] && op_config_q[2] && strobe_pin == trig_polarity_q && fault_q == 5'h0)[*5];
    endsequence
    // edge mode standing for two cycles
    sequence s_edge_mode;
        (!op_config_q[5])[*2];
    endsequence
    a_reset_values: assert property (
        $rose(rst_b) |-> op_config_q == 8'hb4 && thr_sel_q == 2'h0 && flash_duration_q == 4'hf
        && flash_current_q == 4'h6 && assist_current_q == 3'h1 && led_two_q && trig_polarity_q
        && throttle_en_q && fault_q == 5'h0) else $error("register value wrong after reset");
    a_mode_map: assert property (
        led_mode_q == (($past(op_config_q[1:0]) == 2'h1) ? 2'h0 : $past(op_config_q[1:0])))
        else $error("led mode does not follow mode bits");
    a_fault_disables: assert property (
        fault_q != 5'h0 |-> !led_enable_q) else $error("led enabled while a fault flag stands");
    a_torch_gate: assert property (
        !op_config_q[4] |=> !torch_on_q) else $error("torch on while torch pin not allowed");
    a_throttle_gate: assert property (
        !throttle_en_q |=> !throttle_q) else $error("throttle active while disabled");
    a_strobe_gate: assert property (
        (!op_config_q[2])[*4] |=> !flash_trigger_q) else $error("trigger while strobe disabled");
    a_level_trigger: assert property (
        s_level_active |-> flash_trigger_q) else $error("level trigger missing");
    a_edge_pulse: assert property (
        s_edge_mode ##0 $rose(flash_trigger_q) |=> !flash_trigger_q)
        else $error("edge trigger longer than one cycle");
    a_overvolt_flag: assert property (
        $rose(fault_overvolt) |-> ##[1:6] fault_q[4]) else $error("overvoltage flag not set");
endmodule

bind flash_led_driver_config_regs flash_led_driver_config_regs_assertions
    flash_led_driver_config_regs_assertions_inst (.*);

// *** tb/i2c_host_model.sv ***
`timescale 1ns/10ps
module i2c_host_model (
    // bus wires, sda resolved by the bench with a pull-up
    output logic      scl,
    output logic      sda_oe,
    input  wire logic sda
);
    // ------------------------------------------------------------------
    // bit level master, 64 ns per bit
    // ------------------------------------------------------------------
    logic [7:0] rx_byte;  // last byte read from the device
    event       rx_done;  // fires once per byte read
    // idle: clock stands high, data released
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // data moves mid low phase so it never races the clock edge
    task automatic bit_io(input logic b, output logic r);
        #16 sda_oe = ~b;
        #16 scl = 1'b1;
        #16 r = sda;
        #16 scl = 1'b0;
    endtask
    // start also serves as repeated start
    task automatic start;
        #16 sda_oe = 1'b0;
        #16 scl = 1'b1;
        #32 sda_oe = 1'b1;
        #32 scl = 1'b0;
    endtask
    // stop leaves the clock parked high
    task automatic stop;
        #16 sda_oe = 1'b1;
        #16 scl = 1'b1;
        #32 sda_oe = 1'b0;
        #32;
    endtask
    // byte out, msb first, ack bit read back
    task automatic byte_tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // byte in, then the master ack or nack
    task automatic byte_rx(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
        rx_byte = d;
        -> rx_done;
    endtask
endmodule

// *** tb/flash_led_driver_config_regs_tb.sv ***
`timescale 1ns/10ps
`include "flash_led_driver_config_regs_map.vh"
module flash_led_driver_config_regs_tb;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        clock, rst_b, ce, strobe_pin, torch_pin, tx_mask_pin;  // clock, reset, pins
    logic        scl, m_oe, sda, sda_out_q, sda_oe_q, lt;               // bus; lt: led count
    logic [3:0]  flt, flash_duration_q, flash_current_q;                // fault levels, fields
    logic [1:0]  thr_sel_q, led_mode_q;
    logic [2:0]  assist_current_q;
    logic [7:0]  op_config_q, d [6];                                    // d: burst data
    logic [4:0]  fault_q;
    logic        led_two_q, trig_polarity_q, throttle_en_q, led_enable_q;
    logic        flash_trigger_q, torch_on_q, throttle_q;
    logic [7:0]  expq [$];                                              // expected read bytes
    logic [31:0] seed = 32'hf92b1fff;                                   // xorshift state
    int          err_total = 0, cmp_count = 0;
    // revision value is arbitrary; timeout shortened to 200 cycles
    flash_led_driver_config_regs #(.TIMEOUT_CYCLES(32'd200), .REVISION_ID(8'h3c))
        flash_led_driver_config_regs_inst (.sda_in(sda), .fault_overvolt(flt[3]),
        .fault_short(flt[2]), .fault_overtemp(flt[1]), .fault_cur_limit(flt[0]), .*);
    i2c_host_model i2c_host_model_inst (.scl(scl), .sda_oe(m_oe), .sda(sda));
    // wired-and bus with pull-up
    assign sda = ~((sda_oe_q & ~sda_out_q) | m_oe);
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic send(input logic [7:0] b, input logic ack_exp);
        logic a;
        i2c_host_model_inst.byte_tx(b, a);
        check("ack", {31'h0, ack_exp}, {31'h0, a});
    endtask
    // pointer write then n data bytes; n = 0 only sets the pointer
    task automatic wr(input logic [7:0] ptr, input int n);
        i2c_host_model_inst.start();
        send(`I2C_WR_ADDR, 1'b1);
        send(ptr, 1'b1);
        for (int j = 0; j < n; j++) send(d[j], 1'b1);
        i2c_host_model_inst.stop();
    endtask
    task automatic rd(input logic [7:0] ptr, input int n);
        logic [7:0] b;
        wr(ptr, 0);
        i2c_host_model_inst.start();
        send(`I2C_RD_ADDR, 1'b1);
        for (int j = 0; j < n; j++) i2c_host_model_inst.byte_rx(j < n - 1, b);
        i2c_host_model_inst.stop();
    endtask
    // reset, then read the whole map from the unmapped offset up
    task automatic rst_rd;
        rst_b = 1'b0;
        cyc(20);
        rst_b = 1'b1;
        cyc(5);
        lt = 1'b1;
        expq = '{8'h00, 8'h3c, 8'h0f, 8'h61, 8'hb4, 8'h08, 8'h06};
        rd(8'h00, 7);
    endtask
    // watcher: each byte read is matched against the oldest note
    always @(i2c_host_model_inst.rx_done) begin
        if (expq.size() == 0) check("unexpected read", 32'h0, 32'h1);
        else check("read", {24'h0, expq.pop_front()}, {24'h0, i2c_host_model_inst.rx_byte});
    end
    initial begin
        #500000;
        check("watchdog", 32'h0, 32'h1);
        close_out();
    end
    initial begin
        logic [31:0] v;
        // reset low, ce high, strobe low, torch and tx mask high, no faults
        {rst_b, ce, strobe_pin, torch_pin, tx_mask_pin, flt} = {5'b01011, 4'h0};
        rst_rd();
        i2c_host_model_inst.start();
        send(8'h62, 1'b0);
        i2c_host_model_inst.stop();
        // random bursts from the read-only revision up, one per mode code
        for (int i = 0; i < 4; i++) begin
            v = xs();
            {d[0], d[1], d[2], d[3]} = v;
            v = xs();
            {d[4], d[5]} = {v[15:8], v[7:0] | 8'h04};  // polarity kept high, strobe idle
            d[3][1:0] = i[1:0];
            wr(`REG_SILICON_REV, 6);
            lt = d[4][3];
            expq = '{8'h3c, d[1] & 8'h3f, d[2] & 8'hf7, d[3], {4'h0, lt, 3'h0}, d[5] & 8'h06};
            rd(`REG_SILICON_REV, 6);
            cyc(4);
            check("ports", {d[1][5:0], d[2][7:4], d[2][2:0], d[3], lt, d[5][2:1],
                (i == 1) ? 2'h0 : i[1:0], d[3][4], d[5][1]}, {thr_sel_q, flash_duration_q,
                flash_current_q, assist_current_q, op_config_q, led_two_q, trig_polarity_q,
                throttle_en_q, led_mode_q, torch_on_q, throttle_q});
        end
        // edge mode: one pulse per rising strobe
        d[0] = 8'h94;
        wr(`REG_OP_CONFIG, 1);
        cyc(4);
        strobe_pin = 1'b1;
        for (int k = 0; k < 10 && flash_trigger_q !== 1'b1; k++) cyc(1);
        check("edge trigger", 32'h1, {31'h0, flash_trigger_q});
        if (flash_trigger_q !== 1'b1) close_out();
        cyc(1);
        check("edge trigger end", 32'h0, {31'h0, flash_trigger_q});
        // level mode, active low, strobe held past the timeout
        d[0] = 8'h02;
        wr(`REG_TRIG_SETTINGS, 1);
        d[0] = 8'hb4;
        wr(`REG_OP_CONFIG, 1);
        strobe_pin = 1'b0;
        cyc(10);
        check("level trigger", 32'h1, {31'h0, flash_trigger_q});
        cyc(240);
        check("timeout", 32'h4, {26'h0, fault_q, led_enable_q});
        strobe_pin = 1'b1;
        cyc(4);
        expq.push_back({4'h1, lt, 3'h0});
        rd(`REG_FAULT_FLAGS, 1);
        cyc(4);
        check("cleared", 32'h1, {26'h0, fault_q, led_enable_q});
        // each fault detector in turn: flag, disable, read, clear
        for (int k = 0; k < 4; k++) begin
            v[3:0] = 4'h1 << k;
            flt = v[3:0];
            cyc(8);
            flt = 4'h0;
            check("fault", {26'h0, v[3:1], 1'b0, v[0], 1'b0}, {26'h0, fault_q, led_enable_q});
            expq.push_back({v[3:1], 1'b0, lt, 1'b0, v[0], 1'b0});
            rd(`REG_FAULT_FLAGS, 1);
            cyc(4);
            check("fault cleared", 32'h1, {26'h0, fault_q, led_enable_q});
        end
        strobe_pin = 1'b0;
        rst_rd();
        close_out();
    end
endmodule
